// *** rtl/lcdcb_pkg.sv ***
// Shared offsets, field positions, reset values and types of the LCD clock and bias block
`default_nettype none
package lcdcb_pkg;
  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] LCDCB_OFF_REF = 8'h00;
  localparam logic [7:0] LCDCB_OFF_CST = 8'h04;
  localparam logic [7:0] LCDCB_OFF_SEG0 = 8'h08;
  localparam logic [7:0] LCDCB_OFF_SEG1 = 8'h0C;
  localparam logic [7:0] LCDCB_OFF_SEG2 = 8'h10;
  localparam logic [7:0] LCDCB_OFF_CLK = 8'h14;
  localparam logic [7:0] LCDCB_OFF_CTRL = 8'h18;
  localparam logic [7:0] LCDCB_OFF_STAT = 8'h1C;
  localparam logic [7:0] LCDCB_OFF_PIX = 8'h40;
  localparam logic [7:0] LCDCB_OFF_PIX_LAST = 8'h6C;
  // Reference control fields
  localparam int unsigned LCDCB_REF_IRE = 7;
  localparam int unsigned LCDCB_REF_IRS = 6;
  localparam int unsigned LCDCB_REF_IRI = 5;
  localparam int unsigned LCDCB_REF_BP_LSB = 1;
  localparam logic [7:0] LCDCB_REF_MASK = 8'hEE;
  localparam logic [7:0] LCDCB_CST_MASK = 8'h07;
  // Clock select fields: prescale in 3:0, source in 5:4
  localparam int unsigned LCDCB_CLK_PRE_LSB = 0;
  localparam int unsigned LCDCB_CLK_CS_LSB = 4;
  localparam logic [7:0] LCDCB_CLK_MASK = 8'h3F;
  // Control fields: enable in bit 0, bias mode in 2:1; status: active in bit 0
  localparam int unsigned LCDCB_CTRL_EN = 0;
  localparam int unsigned LCDCB_CTRL_BIAS_LSB = 1;
  localparam logic [7:0] LCDCB_CTRL_MASK = 8'h07;
  localparam int unsigned LCDCB_STAT_ACTIVE = 0;
  // Reset values
  localparam logic [7:0] LCDCB_REG_RST = 8'h00;
  // Fixed system clock divider and pixel store size
  localparam int unsigned LCDCB_SYS_DIV = 256;
  localparam int unsigned LCDCB_PIX_WORDS = 12;
  // AXI responses
  localparam logic [1:0] LCDCB_RESP_OKAY = 2'h0;
  localparam logic [1:0] LCDCB_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {LCDCB_SRC_SYS, LCDCB_SRC_XTAL, LCDCB_SRC_LFO,
                            LCDCB_SRC_LFO_ALT} lcdcb_src_e;
  typedef enum logic [1:0] {LCDCB_BIAS_STATIC, LCDCB_BIAS_HALF, LCDCB_BIAS_THIRD,
                            LCDCB_BIAS_THIRD_ALT} lcdcb_bias_e;
  typedef enum logic [1:0] {LCDCB_RD_IDLE, LCDCB_RD_WAIT, LCDCB_RD_RESP} lcdcb_rd_e;
endpackage
`default_nettype wire

// *** rtl/lcdcb_clk_if.sv ***
// Carrier between the register side and the LCD clock generator
`default_nettype none
interface lcdcb_clk_if;
  import lcdcb_pkg::*;
  lcdcb_src_e src_sel;
  logic [3:0] prescale;
  logic run;
  logic frame_tick;
  modport ctl (output src_sel, output prescale, output run, input frame_tick);
  modport gen (input src_sel, input prescale, input run, output frame_tick);
endinterface
`default_nettype wire

// *** rtl/lcdcb_pixmem.sv ***
// Pixel data store with two registered read ports
`default_nettype none
module lcdcb_pixmem #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 12,
  localparam int unsigned AW = $clog2(DEPTH)
) (
  // Clock
  input wire logic aclk,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  // Read ports
  input wire logic [AW-1:0] raddr_a,
  output logic [WIDTH-1:0] rdata_a,
  input wire logic [AW-1:0] raddr_b,
  output logic [WIDTH-1:0] rdata_b
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] cells;
    logic [WIDTH-1:0] ra;
    logic [WIDTH-1:0] rb;
  } lcdcb_mem_s;
  lcdcb_mem_s q;
  lcdcb_mem_s d;
  // No reset: pixels power up unknown and survive every later reset
  always_comb begin
    d = q;
    if (we) d.cells[waddr] = wdata;
    d.ra = q.cells[raddr_a];
    d.rb = q.cells[raddr_b];
  end
  always_ff @(posedge aclk) begin
    q <= d;
  end
  assign rdata_a = q.ra;
  assign rdata_b = q.rb;
endmodule // lcdcb_pixmem
`default_nettype wire

// *** rtl/lcdcb_clkgen.sv ***
// LCD clock source selection, fixed system divider and frame prescaler
`default_nettype none
module lcdcb_clkgen
  import lcdcb_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Oscillator pins
  input wire logic xtal_osc_pin,
  input wire logic lfo_osc_pin,
  // Settings in, frame tick out
  lcdcb_clk_if.gen clk_if
);
  localparam int unsigned DW = $clog2(LCDCB_SYS_DIV);
  typedef struct packed {
    logic [2:0] xs;
    logic [2:0] ls;
    logic xlev;
    logic llev;
    logic [DW-1:0] div;
    logic src_pulse;
    logic [3:0] cnt;
    logic tick;
  } lcdcb_gen_s;
  lcdcb_gen_s q;
  lcdcb_gen_s d;
  logic sys_pulse;
  logic xrise;
  logic lrise;
  logic pick;
  always_comb begin
    d = q;
    // Three-stage chains; a level counts once stages two and three agree
    d.xs = {q.xs[1:0], xtal_osc_pin};
    d.ls = {q.ls[1:0], lfo_osc_pin};
    xrise = 1'b0;
    lrise = 1'b0;
    if (q.xs[1] == q.xs[2]) begin
      d.xlev = q.xs[2];
      xrise = q.xs[2] & ~q.xlev; // Crystal edges only come if software started it
    end
    if (q.ls[1] == q.ls[2]) begin
      d.llev = q.ls[2];
      lrise = q.ls[2] & ~q.llev;
    end
    // Fixed divide by 256, no programmable part
    d.div = q.div + DW'(1);
    sys_pulse = (q.div == DW'(LCDCB_SYS_DIV - 1));
    // Source choice: 00 system, 01 crystal, 1x slow internal
    case (clk_if.src_sel)
      LCDCB_SRC_SYS: pick = sys_pulse;
      LCDCB_SRC_XTAL: pick = xrise;
      default: pick = lrise;
    endcase
    d.src_pulse = pick;
    d.tick = 1'b0;
    // Prescaler divides by code plus one and restarts after each tick
    if (!clk_if.run) begin
      d.cnt = 4'h0;
    end else if (q.src_pulse) begin
      // Greater-or-equal: a ratio lowered mid-count ticks on the next source pulse instead of wrapping past 15
      if (q.cnt >= clk_if.prescale) begin
        d.cnt = 4'h0;
        d.tick = 1'b1;
      end else begin
        d.cnt = q.cnt + 4'h1;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) q <= '0;
    else q <= d;
  end
  assign clk_if.frame_tick = q.tick;
  // Helper: source pulses since the last tick, and cycles between system pulses
  logic [4:0] seen;
  logic [DW:0] gap;
  always_ff @(posedge aclk) begin
    if (!aresetn || !clk_if.run || q.tick || $changed(clk_if.prescale)) seen <= 5'h00;
    else if (q.src_pulse) seen <= seen + 5'h01;
    if (!aresetn || sys_pulse) gap <= '0;
    else gap <= gap + (DW+1)'(1);
  end
  property p_ratio;
    @(posedge aclk) disable iff (!aresetn)
      (q.src_pulse && clk_if.run && $stable(clk_if.prescale) && seen == 5'(clk_if.prescale))
      |=> q.tick;
  endproperty
  a_ratio: assert property (p_ratio) else $error("prescaler tick missing at ratio");
  property p_sys_div;
    @(posedge aclk) disable iff (!aresetn)
      $rose(q.div == DW'(LCDCB_SYS_DIV - 1)) |-> gap == (DW+1)'(LCDCB_SYS_DIV - 1);
  endproperty
  a_sys_div: assert property (p_sys_div) else $error("system divider not 256");
  property p_halt;
    @(posedge aclk) disable iff (!aresetn)
      !clk_if.run |=> !q.tick ##1 !q.tick;
  endproperty
  a_halt: assert property (p_halt) else $error("frame tick while halted");
endmodule // lcdcb_clkgen
`default_nettype wire

// *** rtl/lcdcb_top.sv ***
// LCD reference, contrast, segment, pixel and clock configuration with AXI4-Lite registers
`default_nettype none
module lcdcb_top
  import lcdcb_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read channels
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Oscillator pins and system state
  input wire logic xtal_osc_pin,
  input wire logic lfo_osc_pin,
  input wire logic sleep_in,
  input wire logic ladder_mode_b,
  input wire logic [1:0] com_select,
  // Reference and contrast controls
  output logic int_ref_on,
  output logic ref_from_fixed,
  output logic ref_from_supply,
  output logic ref_buffer_on,
  output logic contrast_ladder_on,
  output logic [2:0] contrast_taps,
  // Bias and segment controls
  output logic [2:0] bias_pin_connect,
  output logic [1:0] bias_mode,
  output logic ladder_mid_short,
  output logic [23:0] seg_function,
  // Frame timing and pixel row
  output logic frame_tick,
  output logic lcd_active,
  output logic [23:0] pixel_row
);
  typedef struct packed {
    logic [7:0] ref_r;
    logic [7:0] cst;
    logic [7:0] seg0;
    logic [7:0] seg1;
    logic [7:0] seg2;
    logic [7:0] clk;
    logic [7:0] ctrl;
    logic active;
    logic awready;
    logic wready;
    logic aw_have;
    logic w_have;
    logic bvalid;
    logic [1:0] bresp;
    logic [7:0] awaddr;
    logic [7:0] wdata;
    logic wstrb0;
    lcdcb_rd_e rd;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [7:0] raddr;
    logic int_ref_on;
    logic ref_from_fixed;
    logic ref_from_supply;
    logic ref_buffer_on;
    logic contrast_on;
    logic [2:0] taps;
    logic [2:0] bias_pins;
    lcdcb_bias_e bias_mode;
    logic mid_short;
    logic [23:0] seg_fn;
    logic frame_tick;
    logic [1:0] scan;
    logic [1:0] scan_prev;
    logic [23:0] pix_row;
  } lcdcb_top_s;
  localparam lcdcb_top_s RESET_S = '{ref_r: LCDCB_REG_RST, cst: LCDCB_REG_RST,
    seg0: LCDCB_REG_RST, seg1: LCDCB_REG_RST, seg2: LCDCB_REG_RST, clk: LCDCB_REG_RST,
    ctrl: LCDCB_REG_RST, awready: 1'b1, wready: 1'b1, arready: 1'b1, rd: LCDCB_RD_IDLE,
    bias_mode: LCDCB_BIAS_STATIC, default: '0};
  lcdcb_top_s q;
  lcdcb_top_s d;
  // Pixel word decode, shared by the write path, the read path and the memory address
  function automatic logic is_pix(input logic [7:0] a);
    return (a >= LCDCB_OFF_PIX) && (a <= LCDCB_OFF_PIX_LAST) && (a[1:0] == 2'h0);
  endfunction
  function automatic logic [3:0] pix_index(input logic [7:0] a);
    logic [7:0] off;
    off = a - LCDCB_OFF_PIX;
    return off[5:2];
  endfunction
  logic mem_we;
  logic [7:0] mem_rdata_a;
  logic [7:0] mem_rdata_b;
  logic [3:0] scan_addr;
  lcdcb_clk_if clk_if ();
  // Clock settings go out as plain register fields; run follows the active flag
  assign clk_if.src_sel = lcdcb_src_e'(q.clk[LCDCB_CLK_CS_LSB +: 2]);
  assign clk_if.prescale = q.clk[LCDCB_CLK_PRE_LSB +: 4];
  assign clk_if.run = q.active;
  // Pixel write happens in the cycle both halves of a write are held
  assign mem_we = q.aw_have && q.w_have && !q.bvalid && q.wstrb0 && is_pix(q.awaddr);
  assign scan_addr = {2'h0, com_select} * 4'h3 + {2'h0, q.scan};
  lcdcb_clkgen u_clkgen (
    .aclk(aclk),
    .aresetn(aresetn),
    .xtal_osc_pin(xtal_osc_pin),
    .lfo_osc_pin(lfo_osc_pin),
    .clk_if(clk_if.gen)
  );
  lcdcb_pixmem #(.WIDTH(8), .DEPTH(LCDCB_PIX_WORDS)) u_pixmem (
    .aclk(aclk),
    .we(mem_we),
    .waddr(pix_index(q.awaddr)),
    .wdata(q.wdata),
    .raddr_a(pix_index(araddr)),
    .rdata_a(mem_rdata_a),
    .raddr_b(scan_addr),
    .rdata_b(mem_rdata_b)
  );
  always_comb begin
    logic [7:0] rv;
    logic hit;
    d = q;
    rv = 8'h00;
    hit = 1'b1;
    // Write address and data are taken in either order and held until the response
    if (q.awready && awvalid) begin
      d.awaddr = awaddr;
      d.aw_have = 1'b1;
      d.awready = 1'b0;
    end
    if (q.wready && wvalid) begin
      d.wdata = wdata[7:0];
      d.wstrb0 = wstrb[0];
      d.w_have = 1'b1;
      d.wready = 1'b0;
    end
    // Only byte lane 0 carries register bits; masks keep unimplemented bits at zero
    if (q.aw_have && q.w_have && !q.bvalid) begin
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = LCDCB_RESP_OKAY;
      if (q.awaddr == LCDCB_OFF_REF) begin
        if (q.wstrb0) d.ref_r = q.wdata & LCDCB_REF_MASK;
      end else if (q.awaddr == LCDCB_OFF_CST) begin
        if (q.wstrb0) d.cst = q.wdata & LCDCB_CST_MASK;
      end else if (q.awaddr == LCDCB_OFF_SEG0) begin
        if (q.wstrb0) d.seg0 = q.wdata;
      end else if (q.awaddr == LCDCB_OFF_SEG1) begin
        if (q.wstrb0) d.seg1 = q.wdata;
      end else if (q.awaddr == LCDCB_OFF_SEG2) begin
        if (q.wstrb0) d.seg2 = q.wdata;
      end else if (q.awaddr == LCDCB_OFF_CLK) begin
        if (q.wstrb0) d.clk = q.wdata & LCDCB_CLK_MASK;
      end else if (q.awaddr == LCDCB_OFF_CTRL) begin
        if (q.wstrb0) d.ctrl = q.wdata & LCDCB_CTRL_MASK;
      end else if (q.awaddr == LCDCB_OFF_STAT || is_pix(q.awaddr)) begin
        d.bresp = LCDCB_RESP_OKAY;
      end else begin
        d.bresp = LCDCB_RESP_SLVERR;
      end
    end
    if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
      d.awready = 1'b1;
      d.wready = 1'b1;
    end
    // Register read decode; pixel words take one extra cycle through the memory
    if (araddr == LCDCB_OFF_REF) rv = q.ref_r;
    else if (araddr == LCDCB_OFF_CST) rv = q.cst;
    else if (araddr == LCDCB_OFF_SEG0) rv = q.seg0;
    else if (araddr == LCDCB_OFF_SEG1) rv = q.seg1;
    else if (araddr == LCDCB_OFF_SEG2) rv = q.seg2;
    else if (araddr == LCDCB_OFF_CLK) rv = q.clk;
    else if (araddr == LCDCB_OFF_CTRL) rv = q.ctrl;
    else if (araddr == LCDCB_OFF_STAT) rv = {7'h00, q.active};
    else hit = 1'b0;
    case (q.rd)
      LCDCB_RD_IDLE: begin
        if (arvalid) begin
          d.raddr = araddr;
          d.arready = 1'b0;
          if (is_pix(araddr)) begin
            d.rd = LCDCB_RD_WAIT;
          end else begin
            d.rdata = {24'h000000, rv};
            d.rresp = hit ? LCDCB_RESP_OKAY : LCDCB_RESP_SLVERR;
            d.rvalid = 1'b1;
            d.rd = LCDCB_RD_RESP;
          end
        end
      end
      LCDCB_RD_WAIT: begin
        d.rdata = {24'h000000, mem_rdata_a};
        d.rresp = LCDCB_RESP_OKAY;
        d.rvalid = 1'b1;
        d.rd = LCDCB_RD_RESP;
      end
      default: begin
        if (rready) begin
          d.rvalid = 1'b0;
          d.arready = 1'b1;
          d.rd = LCDCB_RD_IDLE;
        end
      end
    endcase
    // System clock source stops in sleep; oscillator sources keep the module active
    d.active = q.ctrl[LCDCB_CTRL_EN]
               && !(sleep_in && q.clk[LCDCB_CLK_CS_LSB +: 2] == 2'(LCDCB_SRC_SYS));
    // Reference path, forced off whenever the module is inactive
    d.int_ref_on = q.ref_r[LCDCB_REF_IRE] && q.active;
    d.ref_from_fixed = d.int_ref_on && q.ref_r[LCDCB_REF_IRS];
    d.ref_from_supply = d.int_ref_on && !q.ref_r[LCDCB_REF_IRS];
    // Idle bit only matters in mode B; cleared, the buffer ignores the ladder mode
    d.ref_buffer_on = d.ref_from_fixed && !(q.ref_r[LCDCB_REF_IRI] && ladder_mode_b);
    d.contrast_on = d.int_ref_on;
    d.taps = q.cst[2:0];
    // Bias pin switches are separate outputs; pin direction and analog select stay put
    d.bias_pins = q.ref_r[LCDCB_REF_BP_LSB +: 3];
    d.bias_mode = lcdcb_bias_e'(q.ctrl[LCDCB_CTRL_BIAS_LSB +: 2]);
    d.mid_short = (d.bias_mode == LCDCB_BIAS_HALF);
    d.seg_fn = {q.seg2, q.seg1, q.seg0};
    d.frame_tick = clk_if.frame_tick;
    // Row scan walks the three banks of the selected common, one read per cycle
    d.scan = (q.scan == 2'h2) ? 2'h0 : q.scan + 2'h1;
    d.scan_prev = q.scan;
    d.pix_row[{q.scan_prev, 3'h0} +: 8] = mem_rdata_b;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) q <= RESET_S;
    else q <= d;
  end
  assign awready = q.awready;
  assign wready = q.wready;
  assign bresp = q.bresp;
  assign bvalid = q.bvalid;
  assign arready = q.arready;
  assign rdata = q.rdata;
  assign rresp = q.rresp;
  assign rvalid = q.rvalid;
  assign int_ref_on = q.int_ref_on;
  assign ref_from_fixed = q.ref_from_fixed;
  assign ref_from_supply = q.ref_from_supply;
  assign ref_buffer_on = q.ref_buffer_on;
  assign contrast_ladder_on = q.contrast_on;
  assign contrast_taps = q.taps;
  assign bias_pin_connect = q.bias_pins;
  assign bias_mode = q.bias_mode;
  assign ladder_mid_short = q.mid_short;
  assign seg_function = q.seg_fn;
  assign frame_tick = q.frame_tick;
  assign lcd_active = q.active;
  assign pixel_row = q.pix_row;
  // A completed register write as seen at the response
  sequence s_wr(logic [7:0] off);
    $rose(q.bvalid) && q.awaddr == off && q.wstrb0;
  endsequence
  property p_ref_off;
    @(posedge aclk) disable iff (!aresetn)
      !q.active |=> !q.int_ref_on && !q.contrast_on;
  endproperty
  a_ref_off: assert property (p_ref_off) else $error("reference on while inactive");
  property p_ref_on;
    @(posedge aclk) disable iff (!aresetn)
      (q.ref_r[LCDCB_REF_IRE] && q.active) |=> q.int_ref_on && q.contrast_on;
  endproperty
  a_ref_on: assert property (p_ref_on) else $error("reference not enabled");
  property p_src;
    @(posedge aclk) disable iff (!aresetn)
      q.int_ref_on |-> (q.ref_from_fixed == $past(q.ref_r[LCDCB_REF_IRS]))
                       && (!q.ref_from_supply == q.ref_from_fixed);
  endproperty
  a_src: assert property (p_src) else $error("reference source wrong");
  property p_buf_idle;
    @(posedge aclk) disable iff (!aresetn)
      (q.ref_r[LCDCB_REF_IRI] && ladder_mode_b) |=> !q.ref_buffer_on;
  endproperty
  a_buf_idle: assert property (p_buf_idle) else $error("buffer on in mode B");
  property p_bias_pins;
    @(posedge aclk) disable iff (!aresetn)
      s_wr(LCDCB_OFF_REF) |=> q.bias_pins == $past(q.wdata[3:1]);
  endproperty
  a_bias_pins: assert property (p_bias_pins) else $error("bias pin switch wrong");
  property p_contrast;
    @(posedge aclk) disable iff (!aresetn)
      s_wr(LCDCB_OFF_CST) |=> q.taps == $past(q.wdata[2:0]);
  endproperty
  a_contrast: assert property (p_contrast) else $error("contrast taps wrong");
  property p_seg;
    @(posedge aclk) disable iff (!aresetn)
      s_wr(LCDCB_OFF_SEG1) |=> q.seg_fn[15:8] == $past(q.wdata);
  endproperty
  a_seg: assert property (p_seg) else $error("segment enable wrong");
  property p_rsv;
    @(posedge aclk) disable iff (!aresetn)
      q.rvalid |-> q.rdata[31:8] == 24'h000000
        && (q.raddr != LCDCB_OFF_REF || (q.rdata[4] == 1'b0 && q.rdata[0] == 1'b0))
        && (q.raddr != LCDCB_OFF_CST || q.rdata[7:3] == 5'h00);
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit reads one");
  property p_pix_read;
    @(posedge aclk) disable iff (!aresetn)
      (q.arready && arvalid && is_pix(araddr)) |-> ##2 q.rvalid;
  endproperty
  a_pix_read: assert property (p_pix_read) else $error("pixel read not answered");
endmodule // lcdcb_top
`default_nettype wire

// *** test/lcdcb_osc_model.sv ***
// Oscillator sources that feed the clock pins of the LCD block
`default_nettype none
module lcdcb_osc_model (
  // Crystal enable from the driver
  input wire logic xtal_en,
  // Oscillator pins
  output logic xtal_osc_pin,
  output logic lfo_osc_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Crystal stands still until started; 40 cycle period, edges away from aclk
  initial begin
    xtal_osc_pin = 1'b0;
    forever #200 xtal_osc_pin = xtal_en & ~xtal_osc_pin;
  end
  // Slow internal oscillator runs free with a 60 cycle period
  initial begin
    lfo_osc_pin = 1'b0;
    forever #300 lfo_osc_pin = ~lfo_osc_pin;
  end
endmodule // lcdcb_osc_model
`default_nettype wire

// *** test/lcd_clock_and_bias_config_tb.sv ***
// Self-checking bench for the LCD clock and bias block
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module lcd_clock_and_bias_config_tb import lcdcb_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic sleep_in, ladder_mode_b, xtal_en, awready, wready, bvalid, arready, rvalid;
  logic int_ref_on, ref_from_fixed, ref_from_supply, ref_buffer_on, contrast_ladder_on;
  logic ladder_mid_short, frame_tick, lcd_active, xtal_osc_pin, lfo_osc_pin;
  logic [7:0] awaddr, araddr, v, pix [12];
  logic [31:0] wdata, rdata, rd_v;
  logic [1:0] com_select, bresp, rresp, rs, bias_mode;
  logic [2:0] contrast_taps, bias_pin_connect;
  logic [23:0] seg_function, pixel_row, e24;
  logic [5:0] cfg [6] = '{6'h00, 6'h03, 6'h0F, 6'h11, 6'h20, 6'h32};
  int per [6] = '{256, 1024, 4096, 80, 60, 180};
  int error_cnt, compares, seed, n;
  // Design under test and its oscillators
  lcdcb_top lcdcb_top_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .xtal_osc_pin(xtal_osc_pin), .lfo_osc_pin(lfo_osc_pin),
    .sleep_in(sleep_in), .ladder_mode_b(ladder_mode_b), .com_select(com_select),
    .int_ref_on(int_ref_on), .ref_from_fixed(ref_from_fixed), .ref_from_supply(ref_from_supply),
    .ref_buffer_on(ref_buffer_on), .contrast_ladder_on(contrast_ladder_on),
    .contrast_taps(contrast_taps), .bias_pin_connect(bias_pin_connect), .bias_mode(bias_mode),
    .ladder_mid_short(ladder_mid_short), .seg_function(seg_function),
    .frame_tick(frame_tick), .lcd_active(lcd_active), .pixel_row(pixel_row));
  lcdcb_osc_model lcdcb_osc_model_i (.xtal_en(xtal_en), .xtal_osc_pin(xtal_osc_pin),
    .lfo_osc_pin(lfo_osc_pin));
  // 100 MHz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Verdict and end of run
  task automatic results();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  // Read: data taken at the edge where rvalid is seen
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // Edges between two frame ticks; the first gap may carry an old setting
  task automatic gap(output int c);
    do @(posedge aclk); while (frame_tick !== 1'b1);
    c = 0;
    do begin
      @(posedge aclk);
      c++;
    end while (frame_tick !== 1'b1);
  endtask
  // Watchdog sized well above the longest expected run
  initial begin
    repeat (60000) @(posedge aclk);
    error_cnt++;
    results();
  end
  // Main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, sleep_in, ladder_mode_b, xtal_en} = 8'h00;
    {awaddr, araddr, wdata, com_select, aresetn} = 51'h0;
    seed = 32'hA7AFE746;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      rd(8'(i * 4), rd_v, rs);
      `CHK("reset value", 32'h00000000, rd_v)
      wr(8'(i * 4), 8'hFF, rs);
      rd(8'(i * 4), rd_v, rs);
      `CHK("read back", {24'h0, i == 0 ? 8'hEE : i == 1 ? 8'h07 : 8'hFF}, rd_v)
    end
    $display("test masks done");
    wr(LCDCB_OFF_CTRL, 8'h01, rs);
    for (int i = 0; i < 10; i++) begin
      v = (i == 0) ? 8'hE1 : (i == 1) ? 8'hC1 : 8'($random(seed));
      ladder_mode_b <= v[0];
      wr(LCDCB_OFF_REF, v, rs);
      repeat (3) @(posedge aclk);
      `CHK("int_ref_on", v[7], int_ref_on)
      `CHK("contrast_ladder_on", v[7], contrast_ladder_on)
      `CHK("ref_from_fixed", v[7] & v[6], ref_from_fixed)
      `CHK("ref_from_supply", v[7] & ~v[6], ref_from_supply)
      `CHK("ref_buffer_on", v[7] & v[6] & ~(v[5] & v[0]), ref_buffer_on)
      `CHK("bias_pin_connect", v[3:1], bias_pin_connect)
    end
    // Module off must drop the reference even with its enable set
    wr(LCDCB_OFF_REF, 8'h80, rs);
    wr(LCDCB_OFF_CTRL, 8'h00, rs);
    repeat (3) @(posedge aclk);
    `CHK("int_ref_on off", 1'b0, int_ref_on)
    `CHK("ladder off", 1'b0, contrast_ladder_on)
    $display("test reference done");
    for (int c = 0; c < 8; c++) begin
      v = 8'($random(seed));
      wr(LCDCB_OFF_CST, {v[7:3], 3'(c)}, rs);
      rd(LCDCB_OFF_CST, rd_v, rs);
      `CHK("contrast read", 32'(c), rd_v)
      `CHK("contrast_taps", 3'(c), contrast_taps)
    end
    for (int b = 0; b < 3; b++) begin
      v = 8'($random(seed));
      e24[8 * b +: 8] = v;
      wr(LCDCB_OFF_SEG0 + 8'(4 * b), v, rs);
    end
    repeat (3) @(posedge aclk);
    `CHK("seg_function", e24, seg_function)
    for (int m = 0; m < 4; m++) begin
      wr(LCDCB_OFF_CTRL, {5'h00, 2'(m), 1'b1}, rs);
      repeat (3) @(posedge aclk);
      `CHK("bias_mode", 2'(m), bias_mode)
      `CHK("ladder_mid_short", m == 1, ladder_mid_short)
    end
    $display("test contrast segment bias done");
    for (int p = 0; p < 12; p++) begin
      pix[p] = 8'($random(seed));
      wr(LCDCB_OFF_PIX + 8'(4 * p), pix[p], rs);
    end
    for (int c = 0; c < 5; c++) begin
      // Last pass follows a second reset, which must keep the pixels
      if (c == 4) aresetn <= 1'b0;
      com_select <= 2'(c % 4);
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (20) @(posedge aclk);
      `CHK("pixel_row", {pix[3 * (c % 4) + 2], pix[3 * (c % 4) + 1], pix[3 * (c % 4)]},
        pixel_row)
    end
    // Pixel word read back through the memory port, after the second reset
    rd(LCDCB_OFF_PIX + 8'h14, rd_v, rs);
    `CHK("pixel read", {24'h000000, pix[5]}, rd_v)
    wr(8'h30, 8'h55, rs);
    `CHK("unmapped write", LCDCB_RESP_SLVERR, rs)
    rd(8'h30, rd_v, rs);
    `CHK("unmapped read", LCDCB_RESP_SLVERR, rs)
    $display("test pixels done");
    // Sleep stops only the system source path
    xtal_en <= 1'b1;
    wr(LCDCB_OFF_CTRL, 8'h01, rs);
    sleep_in <= 1'b1;
    repeat (4) @(posedge aclk);
    `CHK("sleep on sys", 1'b0, lcd_active)
    for (int i = 0; i < 6; i++) begin
      sleep_in <= (i >= 3);
      wr(LCDCB_OFF_CLK, {2'b00, cfg[i]}, rs);
      gap(n);
      gap(n);
      `CHK("tick gap", per[i], n)
    end
    `CHK("active in sleep", 1'b1, lcd_active)
    $display("test clocks done");
    results();
  end
endmodule // lcd_clock_and_bias_config_tb
`default_nettype wire
